// file: bench/sfbl_flash_model.sv
// behavioural serial nor flash answering fast reads
`timescale 1ns/10ps
module sfbl_flash_model #(
  parameter logic [7:0] KEY = 8'h5a
) (
  // link pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  // header contents
  input wire logic [23:0] size_in,
  input wire logic [23:0] start_in,
  // observation
  output logic miso_out,
  output logic drv_out,
  output logic [7:0] op_out,
  output logic [23:0] addr_out,
  output int frames_out
);
  logic [39:0] cmd_q;
  logic [23:0] ptr_q;
  logic [7:0] sh_q;
  int bits_q;
  initial begin
    miso_out = 1'b0;
    drv_out = 1'b0;
    frames_out = 0;
    bits_q = 0;
  end
  // header then pattern, read from any address
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    logic [31:0] h;
    h = a[2] ? {8'h00, start_in} : {8'h00, size_in};
    if (a < 24'h00_0008) begin
      return h[8 * (3 - a[1:0]) +: 8];
    end
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ KEY;
  endfunction : byte_at
  always @(negedge cs_n_in) begin
    bits_q = 0;
    frames_out++;
    drv_out = 1'b1;
  end
  // released line shows the inverse of its last level
  always @(posedge cs_n_in) begin
    drv_out = 1'b0;
    miso_out = ~miso_out;
  end
  // command taken on rising edges, msb first
  always @(posedge sck_in) begin
    if (!cs_n_in && bits_q < 40) begin
      cmd_q = {cmd_q[38:0], mosi_in};
      bits_q++;
      op_out = cmd_q[39:32];
      addr_out = cmd_q[31:8];
      ptr_q = cmd_q[31:8];
    end
  end
  // data launched on falling edges, address auto-increments
  always @(negedge sck_in) begin
    if (!cs_n_in && bits_q >= 40) begin
      if (bits_q % 8 == 0) begin
        sh_q = byte_at(ptr_q);
        ptr_q++;
      end
      miso_out = sh_q[7];
      sh_q = sh_q << 1;
      bits_q++;
    end
  end
endmodule : sfbl_flash_model

// file: bench/sfbl_monitor.sv
// checker on the pins of the serial flash boot loader
`timescale 1ns/10ps
module sfbl_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // flash link
  input wire logic flash_clk_out,
  input wire logic flash_clk_oe_out,
  input wire logic flash_serial_out,
  input wire logic flash_serial_oe_out,
  input wire logic primary_flash_select_n_out,
  input wire logic primary_flash_select_oe_out,
  input wire logic secondary_flash_select_n_out,
  // handshakes and status
  input wire logic exec_done_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic req_reject_out,
  input wire logic init_done_output_out,
  input wire logic boot_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ================================================================
  // deselect time counter, saturating so long idles never wrap
  logic idle_n;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  assign idle_n = primary_flash_select_n_out & secondary_flash_select_n_out;
  assign gap_d = !idle_n ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_d;
    end
  end
  // ================================================================
  // assertions
  a_clk_idle_low: assert property (idle_n |-> !flash_clk_out)
    else $error("link clock high outside a frame");
  a_clk_high_two: assert property ($rose(flash_clk_out) |=> flash_clk_out ##1 !flash_clk_out)
    else $error("link clock high phase not two cycles");
  a_sel_one_only: assert property (primary_flash_select_n_out || secondary_flash_select_n_out)
    else $error("both flash selects low");
  a_gap_min_len: assert property ($fell(idle_n) |-> gap_q >= 8'h1e)
    else $error("deselect time below 300 ns");
  a_data_on_fall: assert property ($changed(flash_serial_out) |-> !flash_clk_out)
    else $error("serial out changed while clock high");
  a_frame_opens: assert property ($fell(idle_n) |-> !flash_clk_out && !flash_serial_out)
    else $error("frame did not open with clock low and opcode msb");
  a_oe_after_rst: assert property ($past(rstn_in) |->
      flash_clk_oe_out && flash_serial_oe_out && primary_flash_select_oe_out)
    else $error("link pins not driven after reset");
  a_boot_primary: assert property (!init_done_output_out && !boot_error_out
      |-> secondary_flash_select_n_out)
    else $error("secondary select used during boot");
  a_done_sticky: assert property (init_done_output_out |=> init_done_output_out)
    else $error("init done dropped");
  a_done_cause: assert property ($rose(init_done_output_out) |-> $past(exec_done_in))
    else $error("init done without routine end");
  a_reject_cause: assert property (req_reject_out |->
      $past(req_valid_in && req_ready_out) && idle_n)
    else $error("reject without a taken request");
  c_reject: cover property (req_reject_out);
  c_init: cover property ($rose(init_done_output_out));
  c_second: cover property ($fell(secondary_flash_select_n_out));
  c_boot_fail: cover property ($rose(boot_error_out));
endmodule : sfbl_monitor

// file: bench/tb_serial_flash_boot_loader.sv
// self-checking bench of the serial flash boot loader
`timescale 1ns/10ps
`include "sfbl_consts.svh"
module tb_serial_flash_boot_loader import sfbl_pkg::*; ;
  logic clk_in = 1'b0;
  logic rstn_in;
  logic fclk, fclk_oe, fso, fso_oe, fsi, pcs_n, pcs_oe, scs_n, clk_w, pcs_w;
  logic exec_start, exec_done, req_valid, req_ready, req_reject;
  logic rd_valid, rd_ready, init_done, boot_err, stall;
  logic p_miso, s_miso, p_drv, s_drv;
  logic [`SFBL_PROG_AW-1:0] prog_addr;
  logic [7:0] prog_data, rd_data, p_op, s_op;
  logic [23:0] hdr_size, hdr_start, p_addr, s_addr;
  sfbl_req_t req;
  int p_fr, s_fr, n_fail, tests_run, seed, k, pf0;
  always #(`SFBL_CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  // floated pins: clock pulled low, select pulled high
  assign clk_w = fclk_oe ? fclk : 1'b0;
  assign pcs_w = pcs_oe ? pcs_n : 1'b1;
  assign fsi = s_drv ? s_miso : p_miso;
  sfbl_flash_model #(.KEY(8'h5a)) u_pflash (.sck_in(clk_w), .cs_n_in(pcs_w), .mosi_in(fso),
    .size_in(hdr_size), .start_in(hdr_start), .miso_out(p_miso), .drv_out(p_drv),
    .op_out(p_op), .addr_out(p_addr), .frames_out(p_fr));
  sfbl_flash_model #(.KEY(8'hc3)) u_sflash (.sck_in(clk_w), .cs_n_in(scs_n), .mosi_in(fso),
    .size_in(hdr_size), .start_in(hdr_start), .miso_out(s_miso), .drv_out(s_drv),
    .op_out(s_op), .addr_out(s_addr), .frames_out(s_fr));
  sfbl_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .flash_clk_out(fclk),
    .flash_clk_oe_out(fclk_oe), .flash_serial_out(fso), .flash_serial_oe_out(fso_oe),
    .flash_serial_in(fsi), .primary_flash_select_n_out(pcs_n),
    .primary_flash_select_oe_out(pcs_oe), .secondary_flash_select_n_out(scs_n),
    .exec_start_out(exec_start), .exec_done_in(exec_done), .prog_rd_addr_in(prog_addr),
    .prog_rd_data_out(prog_data), .req_valid_in(req_valid), .req_ready_out(req_ready),
    .req_in(req), .req_reject_out(req_reject), .rd_data_valid_out(rd_valid),
    .rd_data_ready_in(rd_ready), .rd_data_out(rd_data), .init_done_output_out(init_done),
    .boot_error_out(boot_err));
  // consumer stalls at random, or fully while the buffer is meant to fill
  always @(posedge clk_in) begin
    rd_ready <= !stall && (($random(seed) & 3) != 0);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic bump(input int lim);
    k++;
    if (k > lim) begin
      n_fail++;
      end_sim();
    end
  endtask : bump
  function automatic logic [7:0] exp_byte(input logic s, input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ (s ? 8'hc3 : 8'h5a);
  endfunction : exp_byte
  task automatic do_req(input sfbl_req_t r, input logic bad);
    int pf, sf;
    logic seen;
    pf = p_fr;
    sf = s_fr;
    seen = 1'b0;
    req <= r;
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      bump(500);
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    if (bad) begin
      repeat (3) begin
        @(posedge clk_in);
        seen = seen | req_reject;
      end
      check(seen, 1'b1);
      check(p_fr + s_fr, pf + sf);
    end else begin
      for (int i = 0; i < r.len; i++) begin
        k = 0;
        do begin
          @(posedge clk_in);
          bump(2000);
        end while (!(rd_valid === 1'b1 && rd_ready === 1'b1));
        check(rd_data, exp_byte(r.sel, 24'(r.addr + i)));
      end
      check(r.sel ? s_op : p_op, 8'h0b);
      check(r.sel ? s_addr : p_addr, r.addr);
      check(r.sel ? s_fr - sf : p_fr - pf, 1);
      check(p_fr + s_fr - pf - sf, 1);
    end
  endtask : do_req
  initial begin
    sfbl_req_t r;
    seed = 90559;
    n_fail = 0;
    tests_run = 0;
    rstn_in = 1'b0;
    exec_done = 1'b0;
    req_valid = 1'b0;
    req = '0;
    stall = 1'b0;
    prog_addr = '0;
    hdr_size = 24'h00_0001 + 24'($random(seed) & 24'h00_001f);
    hdr_start = 24'($random(seed) & 24'h1f_fff0) | 24'h00_0010;
    repeat (10) @(posedge clk_in);
    check({fclk_oe, fso_oe, pcs_oe, scs_n, init_done}, 5'h02);
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    k = 0;
    while (exec_start !== 1'b1) begin
      @(posedge clk_in);
      bump(5000);
    end
    check(p_fr, 2);
    check(s_fr, 0);
    check(p_addr, hdr_start);
    for (int i = 0; i < hdr_size; i++) begin
      prog_addr <= i[11:0];
      @(posedge clk_in);
      @(posedge clk_in);
      check(prog_data, exp_byte(1'b0, 24'(hdr_start + i)));
    end
    check(init_done, 1'b0);
    exec_done <= 1'b1;
    repeat (3) @(posedge clk_in);
    exec_done <= 1'b0;
    check(init_done, 1'b1);
    r = '{1'b0, 1'b0, 3'h0, 24'h00_0100, 16'h0000};
    do_req(r, 1'b1);
    r.len = 16'h1401;
    do_req(r, 1'b1);
    r = '{1'b1, 1'b1, 3'h7, 24'h00_0100, 16'h0001};
    do_req(r, 1'b1);
    r.tbl_idx = 3'h6;
    do_req(r, 1'b0);
    repeat (12) begin
      r = '0;
      r.sel = 1'($random(seed));
      r.addr = 24'($random(seed) & 24'h1f_fff0) | 24'h00_0010;
      r.len = 16'h0001 + 16'($random(seed) & 16'h0007);
      do_req(r, 1'b0);
    end
    // buffer fills, link pauses with select held, then drains to the top byte
    r = '{1'b0, 1'b0, 3'h0, 24'h1f_ffe8, 16'h0018};
    stall <= 1'b1;
    fork
      do_req(r, 1'b0);
      begin
        repeat (700) @(posedge clk_in);
        check({pcs_n, fclk, rd_valid}, 3'h1);
        stall <= 1'b0;
      end
    join
    check(init_done, 1'b1);
    check(boot_err, 1'b0);
    // routine larger than program memory: boot stops after the header
    hdr_size = 24'(`SFBL_PROG_DEPTH + 1);
    pf0 = p_fr;
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({fclk_oe, fso_oe, pcs_oe, scs_n, init_done}, 5'h02);
    rstn_in <= 1'b1;
    k = 0;
    while (boot_err !== 1'b1) begin
      @(posedge clk_in);
      bump(1000);
    end
    repeat (50) @(posedge clk_in);
    check(p_fr - pf0, 1);
    check({exec_start, init_done}, 2'h0);
    end_sim();
  end
endmodule : tb_serial_flash_boot_loader
bind sfbl_top sfbl_monitor u_mon (.clk_in(clk_in), .rstn_in(rstn_in),
  .flash_clk_out(flash_clk_out), .flash_clk_oe_out(flash_clk_oe_out),
  .flash_serial_out(flash_serial_out), .flash_serial_oe_out(flash_serial_oe_out),
  .primary_flash_select_n_out(primary_flash_select_n_out),
  .primary_flash_select_oe_out(primary_flash_select_oe_out),
  .secondary_flash_select_n_out(secondary_flash_select_n_out),
  .exec_done_in(exec_done_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .req_reject_out(req_reject_out), .init_done_output_out(init_done_output_out),
  .boot_error_out(boot_error_out));

// file: hdl/sfbl_consts.svh
// constants of the serial flash boot loader
`ifndef SFBL_CONSTS_SVH
`define SFBL_CONSTS_SVH

// ==================================================================
// clocking
`define SFBL_CLK_PERIOD_NS 10
`define SFBL_CLK_KHZ 100000
`define SFBL_SCK_KHZ 33300
`define SFBL_SCK_DIV (`SFBL_CLK_KHZ / `SFBL_SCK_KHZ)
`define SFBL_T_CSH_NS 300
`define SFBL_CSH_CYC ((`SFBL_T_CSH_NS + `SFBL_CLK_PERIOD_NS - 1) / `SFBL_CLK_PERIOD_NS)

// ==================================================================
// command format
`define SFBL_OP_FAST_READ 8'h0B
`define SFBL_ADDR_BYTES 3
`define SFBL_DUMMY_BYTES 1
`define SFBL_CMD_BITS ((1 + `SFBL_ADDR_BYTES + `SFBL_DUMMY_BYTES) * 8)
`define SFBL_DUMMY_VAL 8'h00

// ==================================================================
// boot layout and limits
`define SFBL_HDR_ADDR 24'h00_0000
`define SFBL_HDR_BYTES 8
`define SFBL_FLASH_BYTES 2097152
`define SFBL_PROG_AW 12
`define SFBL_PROG_DEPTH 4096
`define SFBL_SEQ_MAX 16
`define SFBL_SEQ_MAX_BYTES 5120
`define SFBL_TBL_MAX 7
`define SFBL_FIFO_DEPTH 16
`define SFBL_FIFO_W 8

`endif

// file: hdl/sfbl_fifo.sv
// byte fifo between the link engine and its consumers
`timescale 1ns/10ps
module sfbl_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);

  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic [W-1:0] mem_q [D];
  wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_q[rd_ptr_q[AW-1:0]];

  // ================================================================
  // storage, one slot per entry
  genvar gi;
  for (gi = 0; gi < D; gi++) begin : g_slot
    always_ff @(posedge clk_in) begin
      if (push && (wr_ptr_q[AW-1:0] == AW'(gi))) begin
        mem_q[gi] <= in_data_in;
      end
    end
  end

  // ================================================================
  // pointers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule : sfbl_fifo

// file: hdl/sfbl_mem.sv
// program memory of the internal control processor
`timescale 1ns/10ps
module sfbl_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  // read port, data registered
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem_q [1 << AW];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) mem_q[wr_addr_in] <= wr_data_in;
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule : sfbl_mem

// file: hdl/sfbl_pkg.sv
// types of the serial flash boot loader
package sfbl_pkg;

  // ================================================================
  // read request from the internal control processor
  typedef struct packed {
    logic sel;
    logic is_table;
    logic [2:0] tbl_idx;
    logic [23:0] addr;
    logic [15:0] len;
  } sfbl_req_t;

  // ================================================================
  // link engine states
  typedef enum logic [3:0] {
    SP_IDLE = 4'b0001,
    SP_CMD = 4'b0010,
    SP_DATA = 4'b0100,
    SP_GAP = 4'b1000
  } sfbl_spi_st_t;

  // ================================================================
  // boot sequence states
  typedef enum logic [7:0] {
    BT_HDR = 8'b0000_0001,
    BT_HDRW = 8'b0000_0010,
    BT_LOAD = 8'b0000_0100,
    BT_LOADW = 8'b0000_1000,
    BT_EXEC = 8'b0001_0000,
    BT_EXECW = 8'b0010_0000,
    BT_SERVE = 8'b0100_0000,
    BT_FAIL = 8'b1000_0000
  } sfbl_boot_st_t;

endpackage : sfbl_pkg

// file: hdl/sfbl_top.sv
// serial flash master and boot loader
// What this block does
// RQ1 - link master, mode 0, clock idles low
// RQ2 - fixed link clock of 33.3 MHz
// RQ3 - two separately driven flash selects
// RQ4 - boot always reads through primary select
// RQ5 - first read header bytes zero to seven
// RQ6 - copy routine into processor program memory
// RQ7 - run routine, which loads and starts display
// RQ8 - signal init done after routine ends
// RQ9 - only fast read, no signature probing
// RQ10 - opcode, three address, one dummy byte
// RQ11 - memory auto-increments address while streaming
// RQ12 - select stays high at least 300 ns
// RQ13 - three address bytes cover 16 Mb
// RQ14 - sequences up to 5 KB, seven tables
// RQ15 - launch and sample data on falling edge
// RQ16 - outputs floated in reset, secondary excepted
// RQ17 - select held whole read, msb first
// RQ18 - init done low until routine finishes
`timescale 1ns/10ps
`include "sfbl_consts.svh"
module sfbl_top import sfbl_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // flash link
  output logic flash_clk_out,
  output logic flash_clk_oe_out,
  output logic flash_serial_out,
  output logic flash_serial_oe_out,
  input wire logic flash_serial_in,
  output logic primary_flash_select_n_out,
  output logic primary_flash_select_oe_out,
  output logic secondary_flash_select_n_out,
  // internal control processor
  output logic exec_start_out,
  input wire logic exec_done_in,
  input wire logic [`SFBL_PROG_AW-1:0] prog_rd_addr_in,
  output logic [7:0] prog_rd_data_out,
  // flash read requests of the running routine
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire sfbl_req_t req_in,
  output logic req_reject_out,
  output logic rd_data_valid_out,
  input wire logic rd_data_ready_in,
  output logic [7:0] rd_data_out,
  // status
  output logic init_done_output_out,
  output logic boot_error_out
);
  localparam logic [1:0] PH_LAST = 2'(`SFBL_SCK_DIV - 1);
  localparam logic [5:0] BIT_CMD_LAST = 6'(`SFBL_CMD_BITS - 1);
  localparam logic [5:0] GAP_LAST = 6'(`SFBL_CSH_CYC - 1);

  // ==================================================================
  // input synchroniser
  logic din_s1_q;
  logic din_s2_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= flash_serial_in;
      din_s2_q <= din_s1_q;
    end
  end

  // ==================================================================
  // link engine
  sfbl_spi_st_t spi_q, spi_d;
  logic [1:0] ph_q, ph_d;
  logic [5:0] bit_q, bit_d;
  logic [5:0] gap_q, gap_d;
  logic [39:0] sh_out_q, sh_out_d;
  logic [7:0] sh_in_q, sh_in_d;
  logic [23:0] left_q, left_d;
  logic sel_q, sel_d;
  logic sck_q, mosi_q, cs0_n_q, cs1_n_q, oe_q;
  logic mosi_d;
  logic push;
  logic [7:0] push_data;

  logic go;
  logic go_sel;
  logic [23:0] go_addr;
  logic [23:0] go_len;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  wire spi_idle = (spi_q == SP_IDLE);
  wire at_fall = (ph_q == PH_LAST);
  // pause with the clock low at a byte start, so a full fifo stalls the link
  wire stall = (spi_q == SP_DATA) && (bit_q == '0) && (ph_q == '0) && !fifo_in_ready;
  wire run = ((spi_q == SP_CMD) || (spi_q == SP_DATA)) && !stall;
  wire xfer_d = (spi_d == SP_CMD) || (spi_d == SP_DATA);

  always_comb begin
    spi_d = spi_q;
    ph_d = ph_q;
    bit_d = bit_q;
    gap_d = gap_q;
    sh_out_d = sh_out_q;
    sh_in_d = sh_in_q;
    left_d = left_q;
    sel_d = sel_q;
    mosi_d = mosi_q;
    push = 1'b0;
    push_data = {sh_in_q[6:0], din_s2_q};
    case (spi_q)
      SP_IDLE: begin
        if (go) begin
          spi_d = SP_CMD;
          ph_d = '0;
          bit_d = '0;
          sel_d = go_sel;
          left_d = go_len;
          // RQ10 fast read frame
          // RQ13 full 24-bit address
          sh_out_d = {`SFBL_OP_FAST_READ, go_addr, `SFBL_DUMMY_VAL};
          // RQ17 first bit ready before first rise
          mosi_d = sh_out_d[39];
        end
      end
      SP_CMD: begin
        ph_d = at_fall ? 2'b00 : ph_q + 2'b01;
        if (at_fall) begin
          // RQ15 next bit launched on fall
          sh_out_d = {sh_out_q[38:0], 1'b0};
          mosi_d = sh_out_q[38];
          bit_d = bit_q + 6'd1;
          if (bit_q == BIT_CMD_LAST) begin
            spi_d = SP_DATA;
            bit_d = '0;
            mosi_d = 1'b0;
          end
        end
      end
      SP_DATA: begin
        if (run) begin
          ph_d = at_fall ? 2'b00 : ph_q + 2'b01;
        end
        if (run && at_fall) begin
          // RQ15 capture on falling edge
          sh_in_d = push_data;
          bit_d = bit_q + 6'd1;
          if (bit_q == 6'd7) begin
            push = 1'b1;
            bit_d = '0;
            left_d = left_q - 24'd1;
            // RQ11 one address phase streams all bytes
            if (left_q == 24'd1) begin
              spi_d = SP_GAP;
              gap_d = '0;
            end
          end
        end
      end
      SP_GAP: begin
        // RQ12 deselect time
        gap_d = gap_q + 6'd1;
        if (gap_q == GAP_LAST) spi_d = SP_IDLE;
      end
      default: begin
        spi_d = SP_GAP;
        gap_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spi_q <= SP_GAP;
      ph_q <= '0;
      bit_q <= '0;
      gap_q <= '0;
      sh_out_q <= '0;
      sh_in_q <= '0;
      left_q <= '0;
      sel_q <= 1'b0;
    end else begin
      spi_q <= spi_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      gap_q <= gap_d;
      sh_out_q <= sh_out_d;
      sh_in_q <= sh_in_d;
      left_q <= left_d;
      sel_q <= sel_d;
    end
  end

  // ==================================================================
  // pin registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      cs0_n_q <= 1'b1;
      cs1_n_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      // RQ1 RQ2 clock low one phase, high two
      sck_q <= xfer_d && (ph_d != 2'b00);
      mosi_q <= mosi_d;
      // RQ3 RQ17 select per read
      cs0_n_q <= !(xfer_d && !sel_d);
      cs1_n_q <= !(xfer_d && sel_d);
      // RQ16 drive only after reset
      oe_q <= 1'b1;
    end
  end

  assign flash_clk_out = sck_q;
  assign flash_clk_oe_out = oe_q;
  assign flash_serial_out = mosi_q;
  assign flash_serial_oe_out = oe_q;
  assign primary_flash_select_n_out = cs0_n_q;
  assign primary_flash_select_oe_out = oe_q;
  assign secondary_flash_select_n_out = cs1_n_q;

  sfbl_fifo #(
    .W(`SFBL_FIFO_W),
    .D(`SFBL_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // ==================================================================
  // boot sequence
  sfbl_boot_st_t bt_q;
  logic [63:0] hdr_q;
  logic [23:0] cnt_q;
  logic [23:0] size_q;
  logic [23:0] start_q;
  logic exec_q, done_q, err_q, rdy_q, rej_q;
  logic skid_v_q;
  logic [7:0] skid_q;

  wire draining_boot = (bt_q == BT_HDRW) || (bt_q == BT_LOADW);
  wire pop = fifo_out_valid && fifo_out_ready;
  wire [23:0] hdr_size = hdr_q[55:32];
  wire [23:0] hdr_start = hdr_q[23:0];
  wire hdr_bad = (hdr_size == '0) || (hdr_size > 24'(`SFBL_PROG_DEPTH));
  wire accept = req_valid_in && rdy_q;
  // RQ14 sequence size and table count limits
  wire req_bad = (req_in.len == '0) || (req_in.len > 16'(`SFBL_SEQ_MAX_BYTES))
    || (req_in.is_table && (req_in.tbl_idx >= 3'(`SFBL_TBL_MAX)));
  wire mem_we = (bt_q == BT_LOADW) && pop;

  assign fifo_out_ready = draining_boot || !skid_v_q || rd_data_ready_in;
  // RQ4 boot reads on primary select
  // RQ5 header read
  // RQ9 every read is the fast read
  assign go = spi_idle && ((bt_q == BT_HDR) || (bt_q == BT_LOAD) || (accept && !req_bad));
  assign go_sel = (bt_q == BT_SERVE) ? req_in.sel : 1'b0;
  assign go_addr = (bt_q == BT_HDR) ? `SFBL_HDR_ADDR
    : (bt_q == BT_LOAD) ? start_q : req_in.addr;
  assign go_len = (bt_q == BT_HDR) ? 24'(`SFBL_HDR_BYTES)
    : (bt_q == BT_LOAD) ? size_q : {8'h00, req_in.len};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bt_q <= BT_HDR;
      hdr_q <= '0;
      cnt_q <= '0;
      size_q <= '0;
      start_q <= '0;
      exec_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (pop && draining_boot) cnt_q <= cnt_q + 24'd1;
      if (pop && (bt_q == BT_HDRW)) hdr_q <= {hdr_q[55:0], fifo_out_data};
      case (bt_q)
        BT_HDR: begin
          cnt_q <= '0;
          if (spi_idle) bt_q <= BT_HDRW;
        end
        BT_HDRW: begin
          if (cnt_q == 24'(`SFBL_HDR_BYTES)) begin
            size_q <= hdr_size;
            start_q <= hdr_start;
            bt_q <= hdr_bad ? BT_FAIL : BT_LOAD;
          end
        end
        BT_LOAD: begin
          cnt_q <= '0;
          if (spi_idle) bt_q <= BT_LOADW;
        end
        BT_LOADW: begin
          // RQ6 routine fully in program memory
          if (cnt_q == size_q) bt_q <= BT_EXEC;
        end
        BT_EXEC: begin
          // RQ7 start the routine
          exec_q <= 1'b1;
          bt_q <= BT_EXECW;
        end
        BT_EXECW: begin
          // RQ8 RQ18 done once, held until reset
          if (exec_done_in) begin
            done_q <= 1'b1;
            bt_q <= BT_SERVE;
          end
        end
        BT_SERVE: bt_q <= BT_SERVE;
        BT_FAIL: err_q <= 1'b1;
        default: bt_q <= BT_FAIL;
      endcase
    end
  end

  // ==================================================================
  // routine read requests and data output
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdy_q <= 1'b0;
      rej_q <= 1'b0;
      skid_v_q <= 1'b0;
      skid_q <= '0;
    end else begin
      rdy_q <= (bt_q == BT_SERVE) && spi_idle && !accept && !go;
      rej_q <= accept && req_bad;
      if (pop && !draining_boot) begin
        skid_v_q <= 1'b1;
        skid_q <= fifo_out_data;
      end else if (rd_data_ready_in) begin
        skid_v_q <= 1'b0;
      end
    end
  end

  sfbl_mem #(
    .AW(`SFBL_PROG_AW),
    .DW(8)
  ) u_prog (
    .clk_in(clk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(cnt_q[`SFBL_PROG_AW-1:0]),
    .wr_data_in(fifo_out_data),
    .rd_addr_in(prog_rd_addr_in),
    .rd_data_out(prog_rd_data_out)
  );

  assign exec_start_out = exec_q;
  assign init_done_output_out = done_q;
  assign boot_error_out = err_q;
  assign req_ready_out = rdy_q;
  assign req_reject_out = rej_q;
  assign rd_data_valid_out = skid_v_q;
  assign rd_data_out = skid_q;
endmodule : sfbl_top
